// ### sim/rscl_board.sv
// Board pulls on the strap pins, then memory data traffic
`timescale 1ns/1ps
module rscl_board (
    // Clock and phase
    input  wire logic        clk,
    input  wire logic        dataPhase,
    // Pull levels and pin levels
    input  wire logic [11:1] pullLevels,
    output      logic [11:1] straps
);
    logic [11:1] lastR;
    // Toggle every cycle once traffic runs, so a late sample is caught
    always_ff @(posedge clk) lastR <= straps;
    assign straps = dataPhase ? ~lastR : pullLevels;
endmodule

// ### sim/rscl_top_sva.sv
// Port-level assertions for the strap latch top
`timescale 1ns/1ps
module rscl_top_chk #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock, reset and straps
    input wire logic clk, input wire logic rstn, input wire logic [11:1] configStraps,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr, input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrStrobe, input wire logic regRdStrobe,
    input wire logic [DATA_W-1:0] regRdData,
    // Settings, wait and pins
    input wire rscl_pkg::rscl_cfg_t cfgOut, input wire logic cfgValid,
    input wire logic waitRequest, input wire logic waitPin, input wire logic [11:0] dramAddr,
    input wire logic [11:0] dramAddrPinsIn, input wire logic [11:0] dramAddrPinsOut,
    input wire logic [11:0] dramAddrPinsOe, input wire logic [3:1] generalIoIn
);
    logic [11:1] snap;
    // Last strap levels seen before the settings went valid
    always_ff @(posedge clk) if (!cfgValid) snap <= configStraps;
    // Primary codes 101..111 map to 1..3, the rest to 0
    wire logic [2:0] hostExp = snap[11] ? 3'h4 : (snap[3:1] >= 3'h5) ? snap[3:1] - 3'h4 : 3'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_cfg_held: assert property ($past(cfgValid) && cfgValid |-> $stable(cfgOut))
        else $error("settings changed while valid");
    chk_host_decode: assert property (cfgValid |-> cfgOut.hostBus == hostExp)
        else $error("host bus decode wrong");
    chk_endian_map: assert property (cfgValid |-> cfgOut.littleEndian == snap[4])
        else $error("endian setting wrong");
    chk_mem_org: assert property (cfgValid |-> cfgOut.memOrg == snap[7:6])
        else $error("memory organisation wrong");
    chk_wait_follow: assert property ($past(cfgValid) && cfgValid |->
        waitPin == (snap[5] ? $past(waitRequest) : !$past(waitRequest)))
        else $error("wait pin polarity wrong");
    chk_wait_idle: assert property (!cfgValid |-> !waitPin)
        else $error("wait pin active before settings");
    chk_dram_pins: assert property ($past(cfgValid) && cfgValid |->
        dramAddrPinsOut[8:0] == $past(dramAddr[8:0]) && &dramAddrPinsOe[8:0])
        else $error("low address pins not driving");
    chk_no_free: assert property ($past(cfgValid) && cfgValid && snap[7:6] == 2'b11 |->
        dramAddrPinsOut == $past(dramAddr) && dramAddrPinsOe == 12'hfff)
        else $error("address pin freed in full mode");
    chk_gpio_map: assert property ($past(cfgValid) && cfgValid && snap[7:6] == 2'b00 |->
        generalIoIn == {$past(dramAddrPinsIn[9]), $past(dramAddrPinsIn[11:10])})
        else $error("general io mapping wrong");
    chk_spare_read: assert property (regRdStrobe && regAddr == 8'h0d && cfgValid |=>
        regRdData == {5'h00, snap[10:8]})
        else $error("spare readback wrong");
    cover property (cfgValid && cfgOut.memOrg == rscl_pkg::RSCL_MEM_SYM256K);
    cover property (cfgValid && cfgOut.hostBus == rscl_pkg::RSCL_HOST_ALT);
    cover property (cfgValid && waitPin);
endmodule
bind rscl_top rscl_top_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clk(clk), .rstn(rstn),
    .configStraps(configStraps), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .cfgOut(cfgOut), .cfgValid(cfgValid), .waitRequest(waitRequest), .waitPin(waitPin),
    .dramAddr(dramAddr), .dramAddrPinsIn(dramAddrPinsIn), .dramAddrPinsOut(dramAddrPinsOut),
    .dramAddrPinsOe(dramAddrPinsOe), .generalIoIn(generalIoIn));

// ### sim/testbench.sv
// Self-checking bench for the strap latch top
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
    logic clk = 0, rstn = 0, regWrStrobe = 0, regRdStrobe = 0, waitRequest = 0;
    logic dataPhase = 0, rdPend = 0, cfgValid, waitPin;
    logic [7:0] regAddr = 0, regWrData = 0, regRdData, expV;
    logic [11:0] dramAddr = 0, pinsIn = 0, pinsOut, pinsOe;
    logic [11:1] pullLevels = 0, straps;
    logic [3:1] gpIn;
    rscl_pkg::rscl_cfg_t cfgOut;
    logic [7:0] expQ[$];
    int fails = 0, total_checks = 0, seed = 32'hd09b2e0c;
    logic [11:1] pat [5] = '{11'b01010011101, 11'b00110100110, 11'b01111010111,
                             11'b10001101010, 11'b00000000011};
    rscl_board board (.clk(clk), .dataPhase(dataPhase), .pullLevels(pullLevels),
        .straps(straps));
    rscl_top dut (.clk(clk), .rstn(rstn), .configStraps(straps), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
        .regRdData(regRdData), .cfgOut(cfgOut), .cfgValid(cfgValid),
        .waitRequest(waitRequest), .waitPin(waitPin), .dramAddr(dramAddr),
        .dramAddrPinsIn(pinsIn), .dramAddrPinsOut(pinsOut), .dramAddrPinsOe(pinsOe),
        .generalIoIn(gpIn));
    // 50 MHz clock
    always #10 clk = ~clk;
    // Random controller address and wait requests every cycle
    always @(posedge clk) begin
        dramAddr <= $random(seed);
        waitRequest <= $random(seed);
    end
    // Read data stands only the cycle after the strobe
    always @(posedge clk) begin
        if (rdPend) begin
            expV = expQ.pop_front();
            `CHK("regRdData", expV, regRdData)
        end
        rdPend <= regRdStrobe;
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRdStrobe <= 1;
        expQ.push_back(e);
        @(posedge clk);
        regRdStrobe <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1;
        @(posedge clk);
        regWrStrobe <= 0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One reset cycle with the given pull levels
    task automatic run(input logic [11:1] s);
        int i;
        logic [2:0] h, fm;
        @(posedge clk);
        pullLevels <= s;
        dataPhase <= 0;
        rstn <= 0;
        repeat (20) @(posedge clk);
        rstn <= 1;
        i = 0;
        do begin @(negedge clk); i++; end while (cfgValid !== 1'b1 && i < 20);
        if (cfgValid !== 1'b1) begin fails++; summarize(); end
        h = s[11] ? 3'h4 : (s[3:1] >= 3'h5) ? s[3:1] - 3'h4 : 3'h0;
        `CHK("cfgOut", {h, s[4], s[5], s[7:6]}, cfgOut)
        @(posedge clk);
        dataPhase <= 1;
        pinsIn <= $random(seed);
        rd(8'h0d, {5'h00, s[10:8]});
        rd(8'h33, 8'h00);
        rd(8'h0e, {1'b1, s[7:6], s[5], s[4], h});
        wr(8'h0f, 8'h05);
        fm = (s[7:6] == 2'b00) ? 3'b111 : (s[7:6] == 2'b11) ? 3'b000 : 3'b011;
        repeat (2) @(negedge clk);
        `CHK("pinsOe", {~fm[1], ~fm[0], ~fm[2], 9'h1ff}, pinsOe)
        `CHK("pinsOut", {1'b0, fm[0], fm[2]}, pinsOut[11:9] & {fm[1], fm[0], fm[2]})
        rd(8'h10, {1'b0, fm, 1'b0, fm & {pinsIn[9], pinsIn[11:10]}});
        rd(8'h0f, 8'h05);
        repeat (3) @(posedge clk);
        $display("strap test %b done", s);
    endtask
    initial begin
        for (int k = 0; k < 5; k++) run(pat[k]);
        summarize();
    end
endmodule

// ### src/rscl_defs.svh
// Register offsets, field positions and reset values of the strap latch
// Overview of operation
// RQ1: Straps sampled once when reset releases, then held until the next reset.
// RQ2: Primary set host codes: 101 ISA-style, 110 processor bus A, 111 bus B.
// RQ3: Wait strap high means wait output active high, low means active low.
// RQ4: Memory straps pick DRAM organisation and how many address pins carry DRAM.
// RQ5: Memory code 00 frees address pins 11, 10, 9 as general I/O 2, 1, 3.
// RQ6: Codes 01 and 10 free pins 11, 10 as I/O 2, 1; code 11 frees none.
// RQ7: Spare strap a appears at readback register 0x0d bit 0.
// RQ8: Spare strap b appears at readback register 0x0d bit 1.
// RQ9: Spare strap c appears at readback register 0x0d bit 2.
// RQ10: Host set strap low picks primary set, high picks the alternate set.
// RQ11: Endian strap high gives little-endian, low gives big-endian host ordering.
`ifndef RSCL_DEFS_SVH
`define RSCL_DEFS_SVH

// Register offsets
`define RSCL_OFS_SPARE     8'h0d
`define RSCL_OFS_CFG       8'h0e
`define RSCL_OFS_GPIO_CTL  8'h0f
`define RSCL_OFS_GPIO_IN   8'h10

// Spare readback fields
`define RSCL_SPARE_A_BIT   0
`define RSCL_SPARE_B_BIT   1
`define RSCL_SPARE_C_BIT   2

// Configuration readback fields
`define RSCL_CFG_HOST_LSB  0
`define RSCL_CFG_HOST_MSB  2
`define RSCL_CFG_ENDIAN    3
`define RSCL_CFG_WAITPOL   4
`define RSCL_CFG_MEM_LSB   5
`define RSCL_CFG_MEM_MSB   6
`define RSCL_CFG_VALID     7

// General I/O control fields
`define RSCL_GPIO_OUT_LSB  0
`define RSCL_GPIO_OUT_MSB  2
`define RSCL_GPIO_OE_LSB   4
`define RSCL_GPIO_OE_MSB   6

// Reset values
`define RSCL_STRAP_RST     11'h000
`define RSCL_GPIO_CTL_RST  8'h00

`endif

// ### src/rscl_pkg.sv
// Types shared by the strap latch modules
package rscl_pkg;

    // Strap pins in pin order, highest strap first
    typedef struct packed {
        logic       hostSet;
        logic       spareC;
        logic       spareB;
        logic       spareA;
        logic [1:0] memOrg;
        logic       waitPol;
        logic       endian;
        logic [2:0] hostBus;
    } rscl_strap_t;

    // Decoded host bus choice
    typedef enum logic [2:0] {
        RSCL_HOST_OTHER = 3'b000,
        RSCL_HOST_ISA   = 3'b001,
        RSCL_HOST_PROCA = 3'b010,
        RSCL_HOST_PROCB = 3'b011,
        RSCL_HOST_ALT   = 3'b100
    } rscl_host_t;

    // DRAM organisation
    typedef enum logic [1:0] {
        RSCL_MEM_SYM256K = 2'b00,
        RSCL_MEM_SYM1M   = 2'b01,
        RSCL_MEM_ASY256K = 2'b10,
        RSCL_MEM_ASY1M   = 2'b11
    } rscl_mem_t;

    // Static settings handed to the rest of the chip
    typedef struct packed {
        rscl_host_t hostBus;
        logic       littleEndian;
        logic       waitActiveHigh;
        rscl_mem_t  memOrg;
    } rscl_cfg_t;

endpackage

// ### src/rscl_strap_capture.sv
// One-shot capture of the strap levels after reset release
`timescale 1ns/1ps
`include "rscl_defs.svh"

module rscl_strap_capture (
    // Clock and synchronised reset
    input  wire logic                 clk,
    input  wire logic                 rstnSync,
    // Strap levels
    input  wire rscl_pkg::rscl_strap_t strapIn,
    // Captured copy
    output      rscl_pkg::rscl_strap_t strapHeld,
    output      logic                 strapValid
);

    rscl_pkg::rscl_strap_t strapHeld_r;
    logic                  done_r;

    // Load only on the first edge after release, so straps freed later
    // as data pins cannot disturb the settings
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            strapHeld_r <= `RSCL_STRAP_RST;
            done_r      <= 1'b0;
        end else if (!done_r) begin
            strapHeld_r <= strapIn; // RQ1
            done_r      <= 1'b1;
        end
    end

    assign strapHeld  = strapHeld_r;
    assign strapValid = done_r;

endmodule

// ### src/rscl_top.sv
// Strap latch top: reset release, decode, register port and address pin sharing
`timescale 1ns/1ps
`include "rscl_defs.svh"

module rscl_top #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // Strap levels on the memory data pins, straps 11 down to 1
    input  wire logic [11:1]        configStraps,
    // Register port
    input  wire logic [ADDR_W-1:0]  regAddr,
    input  wire logic [DATA_W-1:0]  regWrData,
    input  wire logic               regWrStrobe,
    input  wire logic               regRdStrobe,
    output      logic [DATA_W-1:0]  regRdData,
    // Static settings
    output      rscl_pkg::rscl_cfg_t cfgOut,
    output      logic               cfgValid,
    // Wait request from the host interface and the wait pin
    input  wire logic               waitRequest,
    output      logic               waitPin,
    // DRAM address from the memory controller
    input  wire logic [11:0]        dramAddr,
    // Shared address pins
    input  wire logic [11:0]        dramAddrPinsIn,
    output      logic [11:0]        dramAddrPinsOut,
    output      logic [11:0]        dramAddrPinsOe,
    // General I/O levels seen on freed pins (bits 3..1)
    output      logic [3:1]         generalIoIn
);

    // Parameter check
    if (ADDR_W < 5 || DATA_W < 8) begin : gParamCheck
        $error("rscl_top: ADDR_W must be at least 5 and DATA_W at least 8");
    end

    // Which general I/O lines are freed, bit n-1 for general I/O n
    function automatic logic [2:0] freeMask(input rscl_pkg::rscl_mem_t org);
        logic [2:0] m;
        m = 3'h0;
        unique case (org)
            rscl_pkg::RSCL_MEM_SYM256K: m = 3'h7; // RQ5
            rscl_pkg::RSCL_MEM_SYM1M:   m = 3'h3; // RQ6
            rscl_pkg::RSCL_MEM_ASY256K: m = 3'h3; // RQ6
            rscl_pkg::RSCL_MEM_ASY1M:   m = 3'h0; // RQ6
        endcase
        return m;
    endfunction

    // Reset release through two flip-flops
    logic rstnMeta_r;
    logic rstnSync_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstnMeta_r <= 1'b0;
            rstnSync_r <= 1'b0;
        end else begin
            rstnMeta_r <= 1'b1;
            rstnSync_r <= rstnMeta_r;
        end
    end

    // Strap capture
    rscl_pkg::rscl_strap_t strapHeld;
    logic                  strapValid;

    rscl_strap_capture uCapture (
        .clk        (clk),
        .rstnSync   (rstnSync_r),
        .strapIn    (rscl_pkg::rscl_strap_t'(configStraps)),
        .strapHeld  (strapHeld),
        .strapValid (strapValid)
    );

    // Host bus decode; codes outside the three below belong to other buses
    rscl_pkg::rscl_host_t hostDecoded;
    wire logic            primarySet = !strapHeld.hostSet;
    wire logic            codeIsa    = strapHeld.hostBus == 3'h5;
    wire logic            codeProcA  = strapHeld.hostBus == 3'h6;
    wire logic            codeProcB  = strapHeld.hostBus == 3'h7;

    assign hostDecoded = !primarySet ? rscl_pkg::RSCL_HOST_ALT :   // RQ10
                         codeIsa     ? rscl_pkg::RSCL_HOST_ISA :   // RQ2
                         codeProcA   ? rscl_pkg::RSCL_HOST_PROCA : // RQ2
                         codeProcB   ? rscl_pkg::RSCL_HOST_PROCB : // RQ2
                                       rscl_pkg::RSCL_HOST_OTHER;

    // Settings assembled from the held straps
    rscl_pkg::rscl_cfg_t cfgNxt;
    rscl_pkg::rscl_mem_t memOrg;

    assign memOrg                = rscl_pkg::rscl_mem_t'(strapHeld.memOrg); // RQ4
    assign cfgNxt.hostBus        = hostDecoded;
    assign cfgNxt.littleEndian   = strapHeld.endian;  // RQ11
    assign cfgNxt.waitActiveHigh = strapHeld.waitPol; // RQ3
    assign cfgNxt.memOrg         = memOrg;

    // Freed lines follow the organisation
    wire logic [2:0] gpioFree = freeMask(memOrg);

    // General I/O control register written by software
    // Writes land even for lines that are not freed; the pin logic ignores them
    logic [7:0] gpioCtl_r;
    wire logic  ctlSel   = regAddr == ADDR_W'(`RSCL_OFS_GPIO_CTL);
    wire logic  ctlWrite = regWrStrobe && ctlSel;

    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            gpioCtl_r <= `RSCL_GPIO_CTL_RST;
        end else if (ctlWrite) begin
            gpioCtl_r <= regWrData[7:0];
        end
    end

    wire logic [2:0] gpioOut = gpioCtl_r[`RSCL_GPIO_OUT_MSB:`RSCL_GPIO_OUT_LSB];
    wire logic [2:0] gpioOe  = gpioCtl_r[`RSCL_GPIO_OE_MSB:`RSCL_GPIO_OE_LSB];

    // Address pin sharing: pin 11 is I/O 2, pin 10 is I/O 1, pin 9 is I/O 3
    logic [11:0] pinsOutNxt;
    logic [11:0] pinsOeNxt;
    logic [2:0]  ioInNxt;

    always_comb begin
        pinsOutNxt = dramAddr;
        pinsOeNxt  = 12'hfff;
        ioInNxt    = 3'h0;
        if (!strapValid) begin
            // Keep the pins quiet until the settings exist
            pinsOutNxt = 12'h000;
            pinsOeNxt  = 12'h000;
        end else begin
            if (gpioFree[1]) begin // RQ5
                pinsOutNxt[11] = gpioOut[1];
                pinsOeNxt[11]  = gpioOe[1];
                ioInNxt[1]     = dramAddrPinsIn[11];
            end
            if (gpioFree[0]) begin // RQ6
                pinsOutNxt[10] = gpioOut[0];
                pinsOeNxt[10]  = gpioOe[0];
                ioInNxt[0]     = dramAddrPinsIn[10];
            end
            if (gpioFree[2]) begin // RQ5
                pinsOutNxt[9] = gpioOut[2];
                pinsOeNxt[9]  = gpioOe[2];
                ioInNxt[2]    = dramAddrPinsIn[9];
            end
        end
    end

    // Wait pin level; idle level is the deasserted one for the polarity
    wire logic waitNxt = strapHeld.waitPol ? waitRequest : !waitRequest; // RQ3

    // Read decode
    wire logic [7:0] spareRd = {5'h00, strapHeld.spareC,   // RQ9
                                strapHeld.spareB,           // RQ8
                                strapHeld.spareA};          // RQ7
    wire logic [7:0] cfgRd   = {strapValid, memOrg, strapHeld.waitPol,
                                strapHeld.endian, hostDecoded};
    wire logic [7:0] ioInRd  = {1'b0, gpioFree, 1'b0, generalIoIn[3],
                                generalIoIn[2], generalIoIn[1]};
    wire logic       selSpare = regAddr == ADDR_W'(`RSCL_OFS_SPARE);
    wire logic       selCfg   = regAddr == ADDR_W'(`RSCL_OFS_CFG);
    wire logic       selIoIn  = regAddr == ADDR_W'(`RSCL_OFS_GPIO_IN);
    wire logic [7:0] rdMux    = selSpare ? spareRd :   // RQ7
                                selCfg   ? cfgRd :
                                ctlSel   ? gpioCtl_r :
                                selIoIn  ? ioInRd :
                                           8'h00;      // Unmapped reads zero
    wire logic [DATA_W-1:0] rdNxt = regRdStrobe ? DATA_W'(rdMux) : '0;

    // Output flops; data stand only in the cycle after the read strobe
    // Registered pins cost one cycle of address latency but keep
    // decode glitches off the board
    logic [DATA_W-1:0]   regRdData_r;
    rscl_pkg::rscl_cfg_t cfgOut_r;
    logic                cfgValid_r;
    logic                waitPin_r;
    logic [11:0]         pinsOut_r;
    logic [11:0]         pinsOe_r;
    logic [2:0]          ioIn_r;

    always_ff @(posedge clk or negedge rstnSync_r) begin
        if (!rstnSync_r) begin
            regRdData_r <= '0;
            cfgOut_r    <= '0;
            cfgValid_r  <= 1'b0;
            waitPin_r   <= 1'b0;
            pinsOut_r   <= 12'h000;
            pinsOe_r    <= 12'h000;
            ioIn_r      <= 3'h0;
        end else begin
            regRdData_r <= rdNxt;
            cfgOut_r    <= strapValid ? cfgNxt : '0; // RQ1
            cfgValid_r  <= strapValid;
            waitPin_r   <= strapValid ? waitNxt : 1'b0;
            pinsOut_r   <= pinsOutNxt;
            pinsOe_r    <= pinsOeNxt;
            ioIn_r      <= ioInNxt;
        end
    end

    assign regRdData       = regRdData_r;
    assign cfgOut          = cfgOut_r;
    assign cfgValid        = cfgValid_r;
    assign waitPin         = waitPin_r;
    assign dramAddrPinsOut = pinsOut_r;
    assign dramAddrPinsOe  = pinsOe_r;
    assign generalIoIn     = {ioIn_r[2], ioIn_r[1], ioIn_r[0]};

endmodule
